// ---- bench/rtuh_crc_frame_param_access_tb.sv ----
// Self-checking bench for the host frame controller.
// Assumes the drive model on the far side of the link.
`timescale 1ns/1ps
`default_nettype none
module rtuh_crc_frame_param_access_tb;
  logic        mclk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_write_i = 1'b0, cmd_ascii_i = 1'b0;
  logic [7:0]  cmd_station_i = 8'h00, cmd_group_i = 8'h00, cmd_index_i = 8'h00;
  logic [15:0] cmd_data_i = 16'h0000;
  logic [4:0]  rx_raddr_i = 5'h00;
  logic        slow = 1'b0, bad = 1'b0;
  wire         cmd_ready_o, done_o, ok_o, refused_o, tx_valid_o, tx_ready_i, rx_valid_i;
  wire  [15:0] rd_word_o, crc_o;
  wire  [7:0]  rx_rdata_o, tx_data_o, rx_data_i;
  wire  [4:0]  rx_count_o;
  logic [7:0]  txq[$];
  logic [40:0] vr[10] = '{41'h1_01_0000_0001, 41'h1_01_0001_0001, 41'h1_01_0012_0001, 41'h1_01_0404_0001,
    41'h1_01_0418_0001, 41'h0_01_0418_0001, 41'h0_01_013f_0001, 41'h0_00_0100_0001, 41'h0_ff_0100_0001,
    41'h0_01_0100_000b};
  logic [40:0] va[9] = '{41'h1_01_0002_0007, 41'h1_01_0417_0001, 41'h0_01_0000_000a, 41'h0_01_013e_0001,
    41'h1_01_0301_0002, 41'h1_01_0302_0006, 41'h1_01_0208_0014, 41'h1_01_0208_0016, 41'h1_fe_0406_0005};
  int          errors = 0, checks_done = 0, cyc = 0;
  rtuh_master #(.SILENCE_CYC(50)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i), .cmd_ascii_i(cmd_ascii_i),
    .cmd_station_i(cmd_station_i), .cmd_group_i(cmd_group_i), .cmd_index_i(cmd_index_i),
    .cmd_data_i(cmd_data_i), .done_o(done_o), .ok_o(ok_o), .refused_o(refused_o), .rd_word_o(rd_word_o),
    .crc_o(crc_o), .rx_raddr_i(rx_raddr_i), .rx_rdata_o(rx_rdata_o), .rx_count_o(rx_count_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i));
  rtuh_drive_model #(.GAP(50)) u_drv (.mclk_i(mclk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
    .slow_i(slow), .bad_i(bad));
  initial forever #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (tx_valid_o && tx_ready_i) txq.push_back(tx_data_o);
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      report_and_stop();
    end
  end
  // Reference check over the first n bytes, first byte in the top bits
  function automatic logic [15:0] crc16(input logic [55:0] b, input int n);
    logic [15:0] r;
    r = 16'hffff;
    for (int i = 0; i < n; i++) begin
      r[7:0] = r[7:0] ^ b[55 - 8 * i -: 8];
      repeat (8) r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
    end
    return r;
  endfunction
  task automatic chk(input logic c, input string m);
    checks_done++;
    if (!c) begin
      errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic cmd(input logic [40:0] e, input logic s);
    int n;
    n = 0;
    txq.delete();
    {cmd_write_i, cmd_station_i, cmd_group_i, cmd_index_i, cmd_data_i} = e;
    cmd_ascii_i = s;
    cmd_valid_i = 1'b1;
    while (cmd_ready_o !== 1'b1) begin
      @(posedge mclk_i);
      #1;
    end
    @(posedge mclk_i);
    #1 cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 9000) begin
      @(posedge mclk_i);
      #1 n++;
    end
    chk(n < 9000, "no done");
  endtask
  task automatic t_crc();
    slow = 1'b1;
    cmd(41'h0_01_0101_0002, 1'b0);
    chk(crc_o === 16'h3794 && ok_o === 1'b1, "crc 1");
    chk(txq.size() == 8 && txq[6] === 8'h94 && txq[7] === 8'h37, "crc order");
    slow = 1'b0;
    cmd(41'h1_01_0200_0064, 1'b0);
    chk(crc_o === 16'h9989 && txq[0] === 8'h01, "crc 2");
    cmd(41'h0_01_0200_0002, 1'b0);
    chk(crc_o === 16'hb3c5 && rd_word_o === crc16(56'h01_03_04_00_64_00_00, 7), "crc 3");
  endtask
  task automatic t_tables();
    foreach (vr[i]) begin
      cmd(vr[i], 1'b0);
      chk(refused_o === 1'b1 && txq.size() == 0, "not refused");
    end
    foreach (va[i]) begin
      cmd(va[i], 1'b0);
      chk(refused_o === 1'b0 && ok_o === 1'b1, "refused");
    end
    for (int k = 5; k >= 0; k--) begin
      cmd({25'h1_01_0406, 16'(k)}, 1'b0);
      chk(ok_o === 1'b1 && rd_word_o === crc16({32'h01_06_04_06, 16'(k), 8'h00}, 6), "force");
    end
  endtask
  task automatic t_misc();
    cmd(41'h1_01_0205_1234, 1'b0);
    cmd(41'h0_01_0205_0001, 1'b0);
    rx_raddr_i = 5'h01;
    @(posedge mclk_i);
    #1 chk(rd_word_o === crc16(56'h01_03_02_12_34_00_00, 5) && rx_count_o === 5'h07 && rx_rdata_o === 8'h03,
      "read back");
    bad = 1'b1;
    cmd(41'h0_01_0205_0001, 1'b0);
    chk(ok_o === 1'b0, "bad check passed");
    bad = 1'b0;
    cmd(41'h1_01_0200_0064, 1'b1);
    chk(txq[0] === 8'h3a && txq[$-1] === 8'h0d && txq[$] === 8'h0a && ok_o === 1'b1, "ascii");
  endtask
  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    t_crc();
    t_tables();
    t_misc();
    report_and_stop();
  end
endmodule // rtuh_crc_frame_param_access_tb
bind rtuh_master rtuh_master_props u_props (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i), .cmd_ascii_i(cmd_ascii_i),
  .cmd_station_i(cmd_station_i), .cmd_group_i(cmd_group_i), .cmd_index_i(cmd_index_i),
  .cmd_data_i(cmd_data_i), .done_o(done_o), .refused_o(refused_o), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i));
`default_nettype wire

// ---- bench/rtuh_drive_model.sv ----
// Behavioural drive answering on the byte link.
// Assumes one byte per handshake from the host.
`timescale 1ns/1ps
`default_nettype none
module rtuh_drive_model #(
  parameter int GAP = 50
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Link
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output var  logic       tx_ready_o,
  output var  logic       rx_valid_o,
  output var  logic [7:0] rx_data_o,
  // Pacing and fault
  input  wire logic       slow_i,
  input  wire logic       bad_i
);
  logic [7:0]  q[$];
  logic [7:0]  a[$];
  logic [15:0] mem[0:2047] = '{default: 16'h0000};
  logic [15:0] adr, cnt, c;
  logic        v;
  logic [7:0]  d;
  int          idle = 0;
  function automatic logic [15:0] crc(input logic [7:0] b[$], input int n);
    logic [15:0] r;
    r = 16'hffff;
    for (int i = 0; i < n; i++) begin
      r[7:0] ^= b[i];
      repeat (8) r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
    end
    return r;
  endfunction
  task automatic send();
    tx_ready_o = 1'b0;
    repeat (GAP + 2) @(posedge mclk_i);
    foreach (a[i]) begin
      #1 rx_valid_o = 1'b1;
      rx_data_o = a[i];
      @(posedge mclk_i);
      #1 rx_valid_o = 1'b0;
      rx_data_o = ~a[i];
      repeat (3) @(posedge mclk_i);
    end
    q.delete();
    idle = 0;
  endtask
  initial begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h55;
    forever begin
      @(posedge mclk_i);
      v = tx_valid_i && tx_ready_o;
      d = tx_data_i;
      #1 rx_data_o = ~rx_data_o;
      idle = v ? 0 : idle + 1;
      if (v) q.push_back(d);
      tx_ready_o = !rst_i && !v && (!slow_i || !tx_ready_o);
      if (rst_i) q.delete();
      else if (q.size() > 2 && q[0] == 8'h3a && q[$-1] == 8'h0d && q[$] == 8'h0a) begin
        a = q;
        send();
      end else if (q.size() > 0 && q[0] != 8'h3a && idle > GAP) begin
        a = {};
        if (q.size() == 8 && crc(q, 6) == {q[7], q[6]} && !(q[0] inside {8'h00, 8'hff})) begin
          adr = {q[2], q[3]};
          cnt = {q[4], q[5]};
          a = q[0:1];
          if (q[1] == 8'h06) begin
            if (adr inside {[16'h0002:16'h0011], [16'h0100:16'h013e], [16'h0200:16'h0241], [16'h0300:16'h0307],
                [16'h0405:16'h0417]}) mem[adr[10:0]] = cnt;
            a = q[0:5];
          end else if (cnt <= 16'h000a) begin
            a.push_back({cnt[6:0], 1'b0});
            for (int k = 0; k < cnt; k++) begin
              a.push_back(mem[adr[10:0] + k][15:8]);
              a.push_back(mem[adr[10:0] + k][7:0]);
            end
          end
          c = crc(a, a.size());
          a.push_back(c[7:0] ^ {8{bad_i}});
          a.push_back(c[15:8]);
        end
        send();
      end
    end
  end
endmodule // rtuh_drive_model
`default_nettype wire

// ---- bench/rtuh_master_props.sv ----
// Port assertions for the host frame controller.
// Assumes a bind onto rtuh_master, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module rtuh_master_props (
  // Clock and command
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        cmd_valid_i,
  input wire logic        cmd_ready_o,
  input wire logic        cmd_write_i,
  input wire logic        cmd_ascii_i,
  input wire logic [7:0]  cmd_station_i,
  input wire logic [7:0]  cmd_group_i,
  input wire logic [7:0]  cmd_index_i,
  input wire logic [15:0] cmd_data_i,
  // Result and link
  input wire logic        done_o,
  input wire logic        refused_o,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_ready_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic asc_reg;
  assign take = cmd_valid_i && cmd_ready_o;
  always @(posedge mclk_i) if (take) asc_reg <= cmd_ascii_i;
  a_tx_held: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte changed");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done too long");
  a_station_refused: assert property (take && cmd_station_i inside {8'h00, 8'hff} |-> ##[1:3] done_o && refused_o)
    else $error("bad station taken");
  a_count_refused: assert property (take && !cmd_write_i && cmd_data_i > 16'h000a |-> ##[1:3] done_o && refused_o)
    else $error("big count taken");
  a_write_refused: assert property (take && cmd_write_i && cmd_group_i == 8'h00 && cmd_index_i < 8'h02
    |-> ##[1:3] done_o && refused_o)
    else $error("monitor write taken");
  a_refused_quiet: assert property (refused_o |-> !tx_valid_o)
    else $error("refused but sending");
  a_busy_blocks: assert property (tx_valid_o |-> !cmd_ready_o)
    else $error("ready while sending");
  a_ascii_lf: assert property (asc_reg && tx_valid_o && tx_ready_i && tx_data_o == 8'h0d
    |=> ##[0:2] tx_valid_o && tx_data_o == 8'h0a)
    else $error("no line feed");
endmodule // rtuh_master_props
`default_nettype wire

// ---- pkg/rtuh_defs.vh ----
// Constants for the host-side serial frame controller.
// Assumes a byte-wide transmit/receive path to an external character link.
`ifndef RTUH_DEFS_VH
`define RTUH_DEFS_VH
`define RTUH_CRC_INIT    16'hffff
`define RTUH_CRC_POLY    16'ha001
`define RTUH_CR          8'h0d
`define RTUH_LF          8'h0a
`define RTUH_COLON       8'h3a
`define RTUH_CMD_READ    8'h03
`define RTUH_CMD_WRITE   8'h06
`define RTUH_MAX_WORDS   16'h000a
`define RTUH_ADR_MIN     8'h01
`define RTUH_ADR_MAX     8'hfe
`define RTUH_SILENCE_US  10000
`define RTUH_CLK_MHZ     20
`define RTUH_SILENCE_CYC (`RTUH_SILENCE_US * `RTUH_CLK_MHZ + 1)
`define RTUH_WR0_LO      16'h0002
`define RTUH_WR0_HI      16'h0011
`define RTUH_RD0_LO      16'h0000
`define RTUH_G1_LO       16'h0100
`define RTUH_G1_HI       16'h013e
`define RTUH_G2_LO       16'h0200
`define RTUH_G2_HI       16'h0241
`define RTUH_G3_LO       16'h0300
`define RTUH_G3_HI       16'h0307
`define RTUH_WR4_LO      16'h0405
`define RTUH_RD4_LO      16'h0400
`define RTUH_G4_HI       16'h0417
`define RTUH_LINE_RATE   16'h0301
`define RTUH_FRAMING     16'h0302
`define RTUH_OUT_TEST    16'h0406
`define RTUH_ADJ_SEL     16'h040a
`define RTUH_OFS_LO      16'h040b
`define RTUH_OFS_HI      16'h0415
`define RTUH_UNLOCK      16'h0208
`define RTUH_UNLOCK_ADJ  16'h0014
`define RTUH_UNLOCK_OFS  16'h0016
`endif

// ---- rtl/rtuh_master.v ----
// Host-side frame controller: builds read/write command frames, checks the CRC of binary answers only.
// Assumes an external UART taking tx bytes with valid/ready and giving rx bytes.
`timescale 1ns/1ps
`default_nettype none
`include "rtuh_defs.vh"
module rtuh_master #(
  parameter SILENCE_CYC = `RTUH_SILENCE_CYC,
  parameter RX_DEPTH    = 32,
  parameter RX_AW       = 5
) (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        rst_i,
  // User command
  input  wire        cmd_valid_i,
  output wire        cmd_ready_o,
  input  wire        cmd_write_i,
  input  wire        cmd_ascii_i,
  input  wire [7:0]  cmd_station_i,
  input  wire [7:0]  cmd_group_i,
  input  wire [7:0]  cmd_index_i,
  input  wire [15:0] cmd_data_i,
  // User result
  output reg         done_o,
  output reg         ok_o,
  output reg         refused_o,
  output reg  [15:0] rd_word_o,
  output reg  [15:0] crc_o,
  // Answer byte read-back
  input  wire [RX_AW-1:0] rx_raddr_i,
  output wire [7:0]       rx_rdata_o,
  output reg  [RX_AW-1:0] rx_count_o,
  // Transmit byte link
  output reg         tx_valid_o,
  output reg  [7:0]  tx_data_o,
  input  wire        tx_ready_i,
  // Receive byte link
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_data_i
);
  localparam S_IDLE = 3'd0;
  localparam S_LOAD = 3'd1;
  localparam S_SEND = 3'd2;
  localparam S_CRC  = 3'd3;
  localparam S_GAP  = 3'd4;
  localparam S_RECV = 3'd5;
  localparam S_DONE = 3'd6;

  // One bit step of the reflected check
  function [15:0] crc_step;
    input [15:0] c;
    begin
      crc_step = c[0] ? ((c >> 1) ^ `RTUH_CRC_POLY) : (c >> 1);
    end
  endfunction

  function [7:0] hex_asc;
    input [3:0] n;
    begin
      hex_asc = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    end
  endfunction

  // Address windows as the device applies them
  function addr_ok;
    input        wr;
    input [15:0] a;
    begin
      addr_ok = (a >= `RTUH_G1_LO && a <= `RTUH_G1_HI) ||
                (a >= `RTUH_G2_LO && a <= `RTUH_G2_HI) ||
                (a >= `RTUH_G3_LO && a <= `RTUH_G3_HI);
      if (wr) begin
        addr_ok = addr_ok || (a >= `RTUH_WR0_LO && a <= `RTUH_WR0_HI) ||
                  (a >= `RTUH_WR4_LO && a <= `RTUH_G4_HI);
      end else begin
        addr_ok = addr_ok || (a <= `RTUH_WR0_HI) ||
                  (a >= `RTUH_RD4_LO && a <= `RTUH_G4_HI);
      end
    end
  endfunction

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [15:0] crc_reg;
  reg  [3:0]  bit_reg;
  reg  [4:0]  idx_reg;
  reg  [4:0]  len_reg;
  reg  [7:0]  frame_reg [0:7];
  reg         ascii_reg;
  reg         nib_reg;
  reg  [7:0]  lrc_reg;
  reg         write_reg;
  reg  [31:0] gap_reg;
  reg         last_cr_reg;
  reg  [15:0] rx_crc_reg;
  reg  [7:0]  rx_b1_reg;
  reg  [7:0]  rx_b2_reg;
  reg  [7:0]  rx_station_reg;
  wire [15:0] addr_w;
  wire        cmd_legal_w;
  wire        tx_fire_w;
  integer     k;

  assign addr_w = {cmd_group_i, cmd_index_i};
  // Writes to protected items need unlock and restart beforehand; not tracked here, only address window, station and read count are checked
  assign cmd_legal_w = addr_ok(cmd_write_i, addr_w) &&
                       cmd_station_i >= `RTUH_ADR_MIN && cmd_station_i <= `RTUH_ADR_MAX &&
                       (cmd_write_i || cmd_data_i <= `RTUH_MAX_WORDS);
  assign cmd_ready_o = (state_reg == S_IDLE);
  assign tx_fire_w   = tx_valid_o && tx_ready_i;

  rtuh_rx_mem #(.DEPTH(RX_DEPTH), .AW(RX_AW)) u_rx_mem (
    .mclk_i  (mclk_i),
    .we_i    (rx_valid_i && state_reg == S_RECV),
    .waddr_i (rx_count_o),
    .wdata_i (rx_data_i),
    .raddr_i (rx_raddr_i),
    .rdata_o (rx_rdata_o)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: if (cmd_valid_i) state_next = cmd_legal_w ? S_LOAD : S_DONE;
      S_LOAD: state_next = S_SEND;
      S_SEND: if (idx_reg == len_reg && bit_reg == 4'd8 && !tx_valid_o) state_next = S_CRC;
      S_CRC:  if (tx_fire_w && idx_reg == 5'd2) state_next = S_GAP;
      S_GAP:  if (gap_reg >= SILENCE_CYC) state_next = S_RECV;
      S_RECV: if ((ascii_reg && last_cr_reg && rx_valid_i && rx_data_i == `RTUH_LF) ||
                  (!ascii_reg && gap_reg >= SILENCE_CYC && rx_count_o != 0)) state_next = S_DONE;
      S_DONE: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      crc_reg <= `RTUH_CRC_INIT;
      bit_reg <= 4'd0; idx_reg <= 5'd0; len_reg <= 5'd0;
      ascii_reg <= 1'b0; nib_reg <= 1'b0; lrc_reg <= 8'h00; write_reg <= 1'b0;
      gap_reg <= 32'd0; last_cr_reg <= 1'b0; rx_crc_reg <= `RTUH_CRC_INIT;
      rx_b1_reg <= 8'h00; rx_b2_reg <= 8'h00; rx_station_reg <= 8'h00;
      done_o <= 1'b0; ok_o <= 1'b0; refused_o <= 1'b0;
      rd_word_o <= 16'h0000; crc_o <= 16'h0000; rx_count_o <= {RX_AW{1'b0}};
      tx_valid_o <= 1'b0; tx_data_o <= 8'h00;
      for (k = 0; k < 8; k = k + 1) frame_reg[k] <= 8'h00;
    end else begin
      state_reg <= state_next;
      done_o <= 1'b0;
      if (tx_fire_w) tx_valid_o <= 1'b0;
      case (state_reg)
        S_IDLE: if (cmd_valid_i) begin
          frame_reg[0] <= cmd_station_i;
          frame_reg[1] <= cmd_write_i ? `RTUH_CMD_WRITE : `RTUH_CMD_READ;
          frame_reg[2] <= cmd_group_i;
          frame_reg[3] <= cmd_index_i;
          frame_reg[4] <= cmd_data_i[15:8];
          frame_reg[5] <= cmd_data_i[7:0];
          len_reg <= 5'd6;
          ascii_reg <= cmd_ascii_i; write_reg <= cmd_write_i;
          rx_station_reg <= cmd_station_i;
          crc_reg <= `RTUH_CRC_INIT;
          lrc_reg <= 8'h00; idx_reg <= 5'd0; bit_reg <= 4'd8; nib_reg <= 1'b0;
          refused_o <= !cmd_legal_w;
          ok_o <= 1'b0;
          rx_count_o <= {RX_AW{1'b0}};
          if (cmd_ascii_i && cmd_legal_w) begin
            tx_valid_o <= 1'b1; tx_data_o <= `RTUH_COLON;
          end
        end
        S_LOAD, S_SEND: begin
          if (bit_reg != 4'd8) begin
            crc_reg <= crc_step(crc_reg);
            bit_reg <= bit_reg + 4'd1;
          end else if (!tx_valid_o && idx_reg != len_reg) begin
            // Covered bytes: address through last data
            if (ascii_reg) begin
              tx_data_o <= hex_asc(nib_reg ? frame_reg[idx_reg[2:0]][3:0] : frame_reg[idx_reg[2:0]][7:4]);
              tx_valid_o <= 1'b1;
              nib_reg <= !nib_reg;
              if (nib_reg) begin
                lrc_reg <= lrc_reg + frame_reg[idx_reg[2:0]];
                idx_reg <= idx_reg + 5'd1;
              end
            end else begin
              tx_data_o <= frame_reg[idx_reg[2:0]];
              tx_valid_o <= 1'b1;
              crc_reg <= {crc_reg[15:8], crc_reg[7:0] ^ frame_reg[idx_reg[2:0]]};
              bit_reg <= 4'd0;
              idx_reg <= idx_reg + 5'd1;
            end
          end
          if (state_next == S_CRC) begin
            idx_reg <= 5'd0;
            crc_o <= crc_reg;
          end
        end
        S_CRC: if (!tx_valid_o) begin
          tx_valid_o <= 1'b1;
          if (ascii_reg) begin
            // Two-byte tail: CR then LF only; lrc_reg is never sent
            tx_data_o <= idx_reg[0] ? `RTUH_LF : `RTUH_CR;
          end else begin
            tx_data_o <= idx_reg[0] ? crc_o[15:8] : crc_o[7:0];
          end
          idx_reg <= idx_reg + 5'd1;
          gap_reg <= 32'd0;
        end
        S_GAP: gap_reg <= gap_reg + 32'd1;
        default: ;
      endcase
      if (state_reg == S_GAP && state_next == S_RECV) begin
        gap_reg <= 32'd0;
        rx_crc_reg <= `RTUH_CRC_INIT;
        last_cr_reg <= 1'b0;
      end
      if (state_reg == S_RECV) begin
        if (rx_valid_i) begin
          gap_reg <= 32'd0;
          rx_count_o <= rx_count_o + {{(RX_AW-1){1'b0}}, 1'b1};
          last_cr_reg <= (rx_data_i == `RTUH_CR);
          rx_b2_reg <= rx_b1_reg;
          rx_b1_reg <= rx_data_i;
          if (rx_count_o >= 5'd2) rx_crc_reg <= crc_upd(rx_crc_reg, rx_b2_reg);
        end else begin
          gap_reg <= gap_reg + 32'd1;
        end
      end
      if (state_reg == S_RECV && state_next == S_DONE) begin
        done_o <= 1'b1;
        // ok_o from the check in binary mode, always set in ASCII; rd_word_o loaded either way
        ok_o <= ascii_reg ? 1'b1 :
                (rx_crc_reg == {rx_b1_reg, rx_b2_reg});
        rd_word_o <= {rx_b1_reg, rx_b2_reg};
      end
      if (state_reg == S_IDLE && cmd_valid_i && !cmd_legal_w) done_o <= 1'b0;
      if (state_reg == S_DONE && refused_o) done_o <= 1'b1;
    end
  end

  // Whole byte through the check, used on the receive side
  function [15:0] crc_upd;
    input [15:0] c;
    input [7:0]  b;
    integer j;
    reg [15:0] t;
    begin
      t = {c[15:8], c[7:0] ^ b};
      for (j = 0; j < 8; j = j + 1) t = crc_step(t);
      crc_upd = t;
    end
  endfunction
endmodule // rtuh_master
`default_nettype wire

// ---- rtl/rtuh_rx_mem.v ----
// Small receive byte store for answer frames.
// Assumes a single clock; read data registered.
`timescale 1ns/1ps
`default_nettype none
module rtuh_rx_mem #(
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock
  input  wire          mclk_i,
  // Write side
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [7:0]    wdata_i,
  // Read side
  input  wire [AW-1:0] raddr_i,
  output reg  [7:0]    rdata_o
);
  reg [7:0] mem [0:DEPTH-1];
  always @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // rtuh_rx_mem
`default_nettype wire
